// >>> src/i2c_ack_stop_seq.sv
// I2C master acknowledge and stop sequencer with APB registers
//
// Behaviour
// - Ack enable: SCL low, ack bit on SDA
// - One rate period, then release SCL
// - SCL seen high, one more period, low
// - Ack end clears enable, stops generator, idles
// - Buffer write during ack: dropped, collision
// - SCL held low after ninth clock
// - Stop enable drives SDA low
// - SDA seen low: reload, count to zero
// - Timeout releases SCL, SDA one period later
// - SDA high with SCL high: stop detected
// - Period later: clear stop enable, interrupt
// - Buffer write during stop: dropped, collision
// - After received byte, hold SCL low, wait
`timescale 1ns/1ps
`default_nettype none
module i2c_ack_stop_seq
    import i2c_seq_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        I_CE,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [7:0]  I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic        I_SDA,
    input  wire logic        I_SCL,
    input  wire logic        I_BYTE_END,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    output logic             O_SCL,
    output logic             O_SCL_OE_B,
    output logic             O_SDA,
    output logic             O_SDA_OE_B,
    output logic             O_IRQ
);
    // Address match, shared by write decode and read mux
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        return a == off;
    endfunction

    // States in which the rate generator counts
    function automatic logic timed(input seq_e s);
        return s == ST_ACK_LOW || s == ST_ACK_HIGH ||
               s == ST_STOP_LOW || s == ST_STOP_SCL ||
               s == ST_STOP_END;
    endfunction

    apb_req_s         req;         // Bundled bus request
    logic [1:0]       line_s;      // Synchronised {SCL, SDA}
    logic             scl_s;       // SCL as seen by the sequencer
    logic             sda_s;       // SDA as seen by the sequencer
    seq_e             state_r;     // Sequencer state
    seq_e             state_nxt;
    logic [7:0]       brg_r;       // Rate generator down counter
    logic [7:0]       brg_nxt;
    logic             hold_r;      // SCL parked low between bytes
    logic             hold_nxt;
    logic             ack_en_r;    // Acknowledge sequence enable
    logic             ack_dt_r;    // Bit value sent in the ack slot
    logic             stop_en_r;   // Stop sequence enable
    logic [7:0]       reload_r;    // Rate generator reload value
    logic [7:0]       buf_r;       // Shift buffer
    logic [NSTAT-1:0] stat_r;      // Sticky status bits
    logic [NSTAT-1:0] en_r;        // Interrupt enables
    logic [NSTAT-1:0] evt;         // Status set events
    logic [31:0]      rdata;       // Read mux result

    assign req = '{sel: I_PSEL, en: I_PENABLE, wr: I_PWRITE,
                   addr: I_PADDR, wdata: I_PWDATA};

    // Bus lines are sampled through two flops
    line_sync #(.WIDTH(2)) u_sync (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_ce    (I_CE),
        .i_d     ({I_SCL, I_SDA}),
        .o_q     (line_s)
    );
    assign scl_s = line_s[1];
    assign sda_s = line_s[0];

    // APB decode: one wait state, answer when pready is high
    wire access   = req.sel & req.en;
    wire fire     = access & O_PREADY;
    wire wr_fire  = fire & req.wr;
    wire hit_ctrl = hit(req.addr, OFF_CTRL);
    wire hit_rld  = hit(req.addr, OFF_RELOAD);
    wire hit_buf  = hit(req.addr, OFF_BUF);
    wire hit_stat = hit(req.addr, OFF_STAT);
    wire hit_clr  = hit(req.addr, OFF_CLR);
    wire hit_en   = hit(req.addr, OFF_EN);
    wire mapped   = hit_ctrl | hit_rld | hit_buf | hit_stat |
                    hit_clr | hit_en;
    wire ready_nxt = access & ~O_PREADY;

    // A sequence counts as running from its enable to its clear
    wire busy     = ack_en_r | stop_en_r;
    wire ctrl_wr  = wr_fire & hit_ctrl;
    wire buf_wr   = wr_fire & hit_buf;
    wire write_collision_flag_evt = buf_wr & busy;

    // Rate generator timeout; the high-phase states only time out
    // once SCL is really high, so a stretching slave wins
    wire arb_st   = state_r == ST_ACK_HIGH || state_r == ST_STOP_SCL;
    wire tick     = timed(state_r) && brg_r == 8'h00 &&
                    (!arb_st || scl_s);
    wire ack_done  = state_r == ST_ACK_HIGH && tick;
    wire stop_det  = state_r == ST_STOP_REL && sda_s && scl_s;
    wire stop_done = state_r == ST_STOP_END && tick;

    // Next-state logic
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
                // Ack takes priority if both enables were set at once
                if (ack_en_r)
                    state_nxt = ST_ACK_LOW;
                else if (stop_en_r)
                    state_nxt = ST_STOP_SDA;
            ST_ACK_LOW:
                if (tick)
                    state_nxt = ST_ACK_HIGH;
            ST_ACK_HIGH:
                if (tick)
                    state_nxt = ST_IDLE;
            ST_STOP_SDA:
                if (!sda_s)
                    state_nxt = ST_STOP_LOW;
            ST_STOP_LOW:
                if (tick)
                    state_nxt = ST_STOP_SCL;
            ST_STOP_SCL:
                if (tick)
                    state_nxt = ST_STOP_REL;
            ST_STOP_REL:
                if (stop_det)
                    state_nxt = ST_STOP_END;
            ST_STOP_END:
                if (tick)
                    state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    // Reload on entry to a timed state, while SCL is still held low
    // by another party, and whenever the generator is off
    wire brg_load = !timed(state_nxt) || state_nxt != state_r ||
                    (arb_st && !scl_s);
    assign brg_nxt = brg_load ? reload_r :
                     (brg_r != 8'h00) ? brg_r - 8'h01 : brg_r;

    // SCL park: set at byte end and after an ack, freed by a sequence;
    // a sequence start beats a byte end in the same cycle, otherwise
    // SCL would stay parked and the ack high phase would never end
    assign hold_nxt = (state_r == ST_IDLE && state_nxt != ST_IDLE) ?
                      1'b0 :
                      (I_BYTE_END && state_r == ST_IDLE) ? 1'b1 :
                      ack_done ? 1'b1 : hold_r;

    // Pin drive follows the next state so pins and state agree
    wire scl_drv = hold_nxt || state_nxt == ST_ACK_LOW ||
                   state_nxt == ST_STOP_SDA ||
                   state_nxt == ST_STOP_LOW;
    wire ack_slot = state_nxt == ST_ACK_LOW ||
                    state_nxt == ST_ACK_HIGH;
    wire sda_drv = (ack_slot && !ack_dt_r) ||
                   state_nxt == ST_STOP_SDA ||
                   state_nxt == ST_STOP_LOW ||
                   state_nxt == ST_STOP_SCL;

    // Status events
    assign evt[STAT_STOP_DET] = stop_det;
    assign evt[STAT_WRITE_COLLISION_FLAG]     = write_collision_flag_evt;
    assign evt[STAT_IRQ]      = ack_done | stop_done;

    // Read mux; write-only clear reads as zero
    wire [31:0] ctrl_rd = {27'h0, hold_r, state_r != ST_IDLE,
                           stop_en_r, ack_dt_r, ack_en_r};
    assign rdata = hit_ctrl ? ctrl_rd :
                   hit_rld  ? {24'h0, reload_r} :
                   hit_buf  ? {24'h0, buf_r} :
                   hit_stat ? {29'h0, stat_r} :
                   hit_en   ? {29'h0, en_r} : 32'h0;

    // Sequencer state and rate generator
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state_r <= ST_IDLE;
            brg_r   <= RELOAD_RST;
            hold_r  <= 1'b0;
        end
        else if (I_CE)
        begin
            state_r <= state_nxt;
            brg_r   <= brg_nxt;
            hold_r  <= hold_nxt;
        end
    end

    // Control bits: software sets enables only when idle, hardware
    // clears them; a clear never races a set since both can't occur
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ack_en_r  <= 1'b0;
            ack_dt_r  <= 1'b0;
            stop_en_r <= 1'b0;
        end
        else if (I_CE)
        begin
            if (ack_done)
                ack_en_r <= 1'b0;
            else if (ctrl_wr && !busy && req.wdata[CTRL_ACK_EN])
                ack_en_r <= 1'b1;
            if (stop_done)
                stop_en_r <= 1'b0;
            else if (ctrl_wr && !busy && req.wdata[CTRL_STOP_EN])
                stop_en_r <= 1'b1;
            // Ack value is frozen while a sequence drives it
            if (ctrl_wr && !busy)
                ack_dt_r <= req.wdata[CTRL_ACK_DT];
        end
    end

    // Data registers
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            reload_r <= RELOAD_RST;
            buf_r    <= BUF_RST;
            en_r     <= EN_RST;
        end
        else if (I_CE)
        begin
            if (wr_fire && hit_rld)
                reload_r <= req.wdata[7:0];
            if (buf_wr && !busy)
                buf_r <= req.wdata[7:0];
            if (wr_fire && hit_en)
                en_r <= req.wdata[NSTAT-1:0];
        end
    end

    // Sticky status: a set in the same cycle as a clear wins
    for (genvar i = 0; i < NSTAT; i++)
    begin : g_stat
        always_ff @(posedge I_CLK or negedge I_RST_B)
        begin
            if (!I_RST_B)
                stat_r[i] <= 1'b0;
            else if (I_CE)
            begin
                if (evt[i])
                    stat_r[i] <= 1'b1;
                else if (wr_fire && hit_clr && req.wdata[i])
                    stat_r[i] <= 1'b0;
            end
        end
    end

    // Registered outputs; the interrupt lags its status by one cycle
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            O_PRDATA   <= 32'h0;
            O_PREADY   <= 1'b0;
            O_PSLVERR  <= 1'b0;
            O_SCL      <= 1'b0;
            O_SDA      <= 1'b0;
            O_SCL_OE_B <= 1'b1;
            O_SDA_OE_B <= 1'b1;
            O_IRQ      <= 1'b0;
        end
        else if (I_CE)
        begin
            O_PREADY   <= ready_nxt;
            O_PRDATA   <= ready_nxt && !req.wr ? rdata : 32'h0;
            O_PSLVERR  <= ready_nxt && !mapped;
            O_SCL      <= 1'b0;
            O_SDA      <= 1'b0;
            O_SCL_OE_B <= ~scl_drv;
            O_SDA_OE_B <= ~sda_drv;
            O_IRQ      <= |(stat_r & en_r);
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_B);

    AST_ACK_DRIVE: assert property (
        state_r == ST_ACK_LOW |-> !O_SCL_OE_B && O_SDA_OE_B == ack_dt_r)
        else $error("ack bit not presented with SCL low");
    AST_ACK_RELEASE: assert property (
        I_CE && state_r == ST_ACK_LOW && brg_r == 8'h00
        |=> state_r == ST_ACK_HIGH && O_SCL_OE_B)
        else $error("SCL not released after ack low period");
    AST_ACK_ARB: assert property (
        I_CE && state_r == ST_ACK_HIGH && !scl_s
        |=> state_r == ST_ACK_HIGH && brg_r == reload_r)
        else $error("ack high period ran while SCL held low");
    AST_ACK_END: assert property (
        I_CE && ack_done |=> !ack_en_r && state_r == ST_IDLE &&
        !O_SCL_OE_B ##1 !I_CE || brg_r == reload_r)
        else $error("ack sequence did not close properly");
    AST_WRITE_COLLISION_FLAG_ACK: assert property (
        I_CE && buf_wr && ack_en_r
        |=> stat_r[STAT_WRITE_COLLISION_FLAG] && buf_r == $past(buf_r))
        else $error("buffer write during ack not refused");
    AST_STOP_SDA: assert property (
        state_r == ST_STOP_SDA |-> !O_SDA_OE_B && !O_SCL_OE_B)
        else $error("stop did not pull SDA low");
    AST_STOP_LOAD: assert property (
        I_CE && state_r == ST_STOP_SDA && !sda_s
        |=> state_r == ST_STOP_LOW && brg_r == reload_r)
        else $error("generator not reloaded when SDA low");
    AST_STOP_SCL: assert property (
        I_CE && state_r == ST_STOP_LOW && tick
        |=> O_SCL_OE_B && !O_SDA_OE_B && state_r == ST_STOP_SCL)
        else $error("SCL not released before SDA in stop");
    AST_STOP_DET: assert property (
        I_CE && state_r == ST_STOP_REL && sda_s && scl_s
        |=> stat_r[STAT_STOP_DET])
        else $error("stop detection flag not set");
    AST_STOP_END: assert property (
        I_CE && stop_done |=> !stop_en_r && stat_r[STAT_IRQ])
        else $error("stop end did not clear enable and flag");
    AST_WRITE_COLLISION_FLAG_STOP: assert property (
        I_CE && buf_wr && stop_en_r
        |=> stat_r[STAT_WRITE_COLLISION_FLAG] && $stable(buf_r))
        else $error("buffer write during stop not refused");
    AST_HOLD: assert property (
        hold_r |-> !O_SCL_OE_B)
        else $error("SCL released while parked low");

    COV_ACK: cover property (ack_done ##1 state_r == ST_IDLE);
    COV_STOP: cover property (stop_done);
    COV_STRETCH: cover property (state_r == ST_ACK_HIGH && !scl_s);
    COV_WRITE_COLLISION_FLAG: cover property (write_collision_flag_evt);
endmodule
`default_nettype wire

// >>> include/i2c_seq_pkg.sv
// Shared constants, types and register map of the ack/stop sequencer
package i2c_seq_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_RELOAD = 8'h04;
    localparam logic [7:0] OFF_BUF    = 8'h08;
    localparam logic [7:0] OFF_STAT   = 8'h0c;
    localparam logic [7:0] OFF_CLR    = 8'h10;
    localparam logic [7:0] OFF_EN     = 8'h14;
    // Control register bit positions
    localparam int CTRL_ACK_EN  = 0;
    localparam int CTRL_ACK_DT  = 1;
    localparam int CTRL_STOP_EN = 2;
    localparam int CTRL_BUSY    = 3;
    localparam int CTRL_HOLD    = 4;
    // Status bit positions (status, clear and enable share them)
    localparam int STAT_STOP_DET = 0;
    localparam int STAT_WRITE_COLLISION_FLAG     = 1;
    localparam int STAT_IRQ      = 2;
    localparam int NSTAT         = 3;
    // Values after reset
    localparam logic [7:0]       RELOAD_RST = 8'h04;
    localparam logic [7:0]       BUF_RST    = 8'h00;
    localparam logic [NSTAT-1:0] EN_RST     = 3'h0;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE     = 4'b0000,
        ST_ACK_LOW  = 4'b0001,
        ST_ACK_HIGH = 4'b0010,
        ST_STOP_SDA = 4'b0011,
        ST_STOP_LOW = 4'b0100,
        ST_STOP_SCL = 4'b0101,
        ST_STOP_REL = 4'b0110,
        ST_STOP_END = 4'b0111
    } seq_e;
    // APB request bundle
    typedef struct packed {
        logic        sel;
        logic        en;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } apb_req_s;
endpackage

// >>> src/line_sync.sv
// Two-flop synchroniser for the sampled bus lines
`timescale 1ns/1ps
`default_nettype none
module line_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_b,
    input  wire logic             i_ce,
    input  wire logic [WIDTH-1:0] i_d,
    output logic      [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_r; // First stage, read only by the second

    // Lines idle high, so both stages reset to released
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_r <= '1;
            o_q    <= '1;
        end
        else if (i_ce)
        begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule
`default_nettype wire

// >>> tb/i2c_slave_model.sv
// Wire-level model of the slave side: pull-ups and SCL stretching
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_b,
    input  wire logic       i_scl_oe_b,  // Master pulls SCL while low
    input  wire logic       i_sda_oe_b,  // Master pulls SDA while low
    input  wire logic [3:0] i_stretch,   // Cycles SCL is held after release
    output logic            o_scl,       // SCL wire level
    output logic            o_sda,       // SDA wire level
    output logic            o_bit,       // SDA seen at the last SCL rise
    output logic [7:0]      o_stops      // Stop conditions seen on the wire
);
    logic [3:0] hold_r;  // Stretch cycles still to go
    logic       oe_q_r;  // Master SCL release of last cycle
    logic       scl_q_r; // SCL wire of last cycle
    logic       sda_q_r; // SDA wire of last cycle
    wire        rel;     // Master released SCL in this cycle
    assign rel = i_scl_oe_b & ~oe_q_r;
    // Released lines float to the pull-up level; a slow slave holds SCL
    assign o_scl = i_scl_oe_b & ~(rel & |i_stretch) & (hold_r == 4'h0);
    assign o_sda = i_sda_oe_b;
    // Stretch, bit capture and stop detection on the wire
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            hold_r  <= 4'h0;
            oe_q_r  <= 1'b1;
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
            o_bit   <= 1'b1;
            o_stops <= 8'h00;
        end
        else
        begin
            oe_q_r  <= i_scl_oe_b;
            scl_q_r <= o_scl;
            sda_q_r <= o_sda;
            // Stretch restarts on every release by the master
            if (rel && |i_stretch)
                hold_r <= i_stretch - 4'h1;
            else if (|hold_r)
                hold_r <= hold_r - 4'h1;
            if (o_scl && !scl_q_r)
                o_bit <= o_sda;
            // SDA rising while SCL is high closes the transfer
            if (o_sda && !sda_q_r && o_scl && scl_q_r)
                o_stops <= o_stops + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_i2c_ack_stop_seq.sv
// Self-checking bench for the ack and stop sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_ack_stop_seq
    import i2c_seq_pkg::*;
;
    logic        clk = 0, rst_b = 0, psel = 0, stop_sequence_enable = 0, pwr = 0, bend = 0;
    logic [7:0]  paddr = 8'h00;  // APB address
    logic [31:0] pwdata = 0;     // APB write data
    logic [31:0] prdata, q, st = 93;
    logic        pready, pslverr, scl, scl_oe_b, sda, sda_oe_b, irq, e;
    logic        scl_w, sda_w, bit_s, scl_p = 1, ce = 1;
    logic [3:0]  stretch = 4'h0; // Slave stretch length
    logic [7:0]  stops, s0, bexp;
    int          n_errors = 0, n_tests = 0, cyc = 0, t_rise, t_fall, t_sda;
    int          tw, p, s, i;
    logic        ackv, sda_p = 1;
    always #50 clk = ~clk;
    i2c_ack_stop_seq i_i2c_ack_stop_seq (.I_CLK(clk), .I_RST_B(rst_b),
        .I_CE(ce), .I_PSEL(psel), .I_PENABLE(stop_sequence_enable), .I_PWRITE(pwr),
        .I_PADDR(paddr), .I_PWDATA(pwdata), .I_SDA(sda_w), .I_SCL(scl_w),
        .I_BYTE_END(bend), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_SCL(scl), .O_SCL_OE_B(scl_oe_b),
        .O_SDA(sda), .O_SDA_OE_B(sda_oe_b), .O_IRQ(irq));
    i2c_slave_model i_i2c_slave_model (.i_clk(clk), .i_rst_b(rst_b),
        .i_scl_oe_b(scl_oe_b), .i_sda_oe_b(sda_oe_b), .i_stretch(stretch),
        .o_scl(scl_w), .o_sda(sda_w), .o_bit(bit_s), .o_stops(stops));
    // Verdict and end of run, reached from the sequence and the timeout
    task end_of_test();
        if (n_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Compare one value and count it
    task check(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %0t %s", $time, m);
        end
    endtask
    // Repeatable xorshift stream seeded at 93
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    // Window test for measured line timing
    function automatic logic inr(input int x, input int lo, input int hi);
        return (x >= lo) && (x <= hi);
    endfunction
    // One APB transfer; read data and error land in q and e
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1; stop_sequence_enable <= 0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        stop_sequence_enable <= 1;
        // No wait count is assumed, only a bound against a hang
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 40);
        if (k == 40)
            check(0, 1, "no pready");
        q = prdata;
        e = pslverr;
        psel <= 0; stop_sequence_enable <= 0;
    endtask
    // Poll control until both sequences are over
    task wait_done();
        int k;
        for (k = 0; k < 300; k++)
        begin
            apb(0, OFF_CTRL, 0);
            if (q[CTRL_ACK_EN] === 0 && q[CTRL_STOP_EN] === 0 && q[CTRL_BUSY] === 0)
                break;
        end
    endtask
    // Line edge times and the run-length ceiling
    always @(posedge clk)
    begin
        cyc++;
        if (scl_w && !scl_p) t_rise = cyc;
        if (!scl_w && scl_p) t_fall = cyc;
        if (sda_w && !sda_p) t_sda = cyc;
        scl_p = scl_w;
        sda_p = sda_w;
        if (cyc > 40000)
        begin
            n_errors++;
            end_of_test();
        end
    end
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1;
        apb(0, OFF_RELOAD, 0); check(q, {24'h0, RELOAD_RST}, "reload rst");
        apb(0, OFF_STAT, 0); check(q, 0, "status rst");
        apb(0, 8'h3c, 0); check({q[0], e}, 2'b01, "unmapped");
        check({scl_w, sda_w}, 2'b11, "lines idle");
        check({scl, sda}, 2'b00, "drive value");
        bexp = 8'h5a;
        apb(1, OFF_BUF, 32'h5a); apb(0, OFF_BUF, 0); check(q, bexp, "buf idle");
        for (i = 0; i < 8; i++)
        begin
            p = (rnd() % 8) + 3;
            s = (i == 0) ? 0 : (i == 1) ? 15 : rnd() % 4;
            stretch <= s[3:0];
            ackv = (rnd() & 32'h1) != 0;
            apb(1, OFF_RELOAD, p - 1);
            apb(1, OFF_EN, 1 << STAT_IRQ);
            // Clock enable low: a byte end must leave SCL released
            ce <= 0;
            @(posedge clk) bend <= 1;
            @(posedge clk) bend <= 0;
            repeat (2) @(posedge clk);
            check(scl_w, 1, "ce freeze");
            ce <= 1;
            @(posedge clk) bend <= 1;
            @(posedge clk) bend <= 0;
            repeat (3) @(posedge clk);
            check(scl_w, 0, "scl parked");
            apb(0, OFF_CTRL, 0); check(q[CTRL_HOLD], 1, "park flag");
            apb(1, OFF_CTRL, ackv << CTRL_ACK_DT);
            apb(1, OFF_CTRL, (ackv << CTRL_ACK_DT) | (1 << CTRL_ACK_EN));
            apb(1, OFF_BUF, rnd() & 32'hff);
            // Enables written while the ack runs are ignored
            apb(1, OFF_CTRL, 1 << CTRL_STOP_EN);
            apb(0, OFF_CTRL, 0); check(q[CTRL_STOP_EN], 0, "ctrl busy");
            wait_done();
            check(bit_s, ackv, "ack bit");
            check(inr(t_fall - t_rise, p + 1, p + 5), 1, "ack high");
            check(q[CTRL_ACK_EN], 0, "ack enable");
            check(scl_w, 0, "scl after ack");
            apb(0, OFF_BUF, 0); check(q, bexp, "buf in ack");
            apb(0, OFF_STAT, 0); check(q[2:1], 2'b11, "write_collision_flag ack");
            check(irq, 1, "irq on");
            apb(1, OFF_CLR, 32'h7);
            repeat (2) @(posedge clk);
            check(irq, 0, "irq cleared");
            s0 = stops;
            apb(1, OFF_CTRL, 1 << CTRL_STOP_EN);
            tw = cyc;
            repeat (2) @(posedge clk);
            check(sda_w, 0, "sda low");
            apb(1, OFF_BUF, rnd() & 32'hff);
            wait_done();
            check(bit_s, 0, "sda at scl rise");
            check(inr(t_rise - tw, p, p + 7 + s), 1, "stop scl");
            check(inr(t_sda - t_rise, p + 1, p + 5), 1, "stop sda");
            check(stops, s0 + 8'h01, "stop seen");
            check({scl_w, sda_w}, 2'b11, "released");
            check(q[CTRL_STOP_EN], 0, "stop enable");
            apb(0, OFF_STAT, 0); check(q[2:0], 3'h7, "stop status");
            apb(0, OFF_BUF, 0); check(q, bexp, "buf in stop");
            apb(1, OFF_EN, 0);
            repeat (2) @(posedge clk);
            check(irq, 0, "irq masked");
            apb(1, OFF_CLR, 32'h7); apb(0, OFF_STAT, 0); check(q, 0, "clear");
        end
        end_of_test();
    end
endmodule
`default_nettype wire
